//--- src/clock_timer_control.sv
// clock timer registers behind an axi4-lite slave
`timescale 1ns/1ps

// How it works
// R1 - eight-bit count read as two nibbles
// R2 - count nibble registers ignore all writes
// R3 - low read freezes high nibble briefly
// R4 - reset clears the count to zero
// R5 - writing one to clear zeroes count
// R6 - clear bit always reads back zero
// R7 - clear while running keeps counting on
// R8 - clear while stopped holds zero count
// R9 - run bit readable, one starts, zero stops
// R10 - stopped count holds its value
// R11 - restart continues from held count
// R12 - run bit resets to zero
// R13 - four event flags, write one clears
// R14 - mask bits for 32, 8, 2 hz
// R15 - mask bits readable, 1 hz, reset zero
// R16 - flags set on falling edge regardless mask
// R17 - software clears flag before re-enabling
// R18 - irq high while unmasked flag set
module clock_timer_control #(
    parameter int ADDR_W = tick_pkg::MIN_ADDR_W,
    parameter int TICK_CYCLES = tick_pkg::TICK_CYCLES,
    parameter int HOLD_CYCLES = tick_pkg::HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq
);

    // ******************************************************
    // elaboration checks
    // ******************************************************
    if (ADDR_W < tick_pkg::MIN_ADDR_W || ADDR_W > 32)
    begin : g_bad_addr
        $error("address width cannot hold the register map");
    end
    if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << tick_pkg::DIV_W))
    begin : g_bad_tick
        $error("tick period out of divider range");
    end
    if (HOLD_CYCLES < 2 || HOLD_CYCLES >= (1 << tick_pkg::DIV_W))
    begin : g_bad_hold
        $error("hold window out of divider range");
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    function automatic tick_pkg::tick_sel_e decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] idx;
        idx = a >> 2;
        if (idx == ADDR_W'(tick_pkg::IDX_CONTROL))
            return tick_pkg::SEL_CONTROL;
        else if (idx == ADDR_W'(tick_pkg::IDX_COUNT_LOW))
            return tick_pkg::SEL_LOW;
        else if (idx == ADDR_W'(tick_pkg::IDX_COUNT_HIGH))
            return tick_pkg::SEL_HIGH;
        else if (idx == ADDR_W'(tick_pkg::IDX_IRQ_ENABLE))
            return tick_pkg::SEL_ENABLE;
        else if (idx == ADDR_W'(tick_pkg::IDX_EVENT_FLAGS))
            return tick_pkg::SEL_FLAGS;
        else
            return tick_pkg::SEL_NONE;
    endfunction

    // ******************************************************
    // state
    // ******************************************************
    logic awready_r;
    logic wready_r;
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [3:0] w_data_r;
    logic w_lane_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic run_r;
    logic [7:0] count_r;
    logic [7:0] count_prev_r;
    logic [3:0] held_high_r;
    logic hold_active_r;
    logic [3:0] flags_r;
    logic [3:0] enable_r;
    logic irq_r;
    logic [31:0] rd_value;
    logic [3:0] fall;
    logic [3:0] flag_clr;
    logic tick;
    logic hold_done;
    logic wr_fire;
    logic rd_fire;
    logic clear_wr;
    logic low_read;
    logic high_read;
    tick_pkg::tick_sel_e wr_sel;
    tick_pkg::tick_sel_e rd_sel;

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign irq = irq_r;

    assign wr_sel = decode(aw_addr_r);
    assign rd_sel = decode(araddr);
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign rd_fire = arvalid && arready_r;
    // only byte lane 0 carries the nibble registers
    assign clear_wr = wr_fire && w_lane_r && wr_sel == tick_pkg::SEL_CONTROL
        && w_data_r[tick_pkg::CLEAR_BIT]; // R5
    assign low_read = rd_fire && rd_sel == tick_pkg::SEL_LOW;
    assign high_read = rd_fire && rd_sel == tick_pkg::SEL_HIGH;
    assign flag_clr = (wr_fire && w_lane_r && wr_sel == tick_pkg::SEL_FLAGS) ? w_data_r : 4'h0;

    // ******************************************************
    // write channels
    // ******************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end
        else if (awvalid && awready_r)
        begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            aw_addr_r <= awaddr;
        end
        else
        begin
            awready_r <= !aw_held_r || wr_fire;
            aw_held_r <= aw_held_r && !wr_fire;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wready_r <= 1'b0;
            w_held_r <= 1'b0;
            w_data_r <= 4'h0;
            w_lane_r <= 1'b0;
        end
        else if (wvalid && wready_r)
        begin
            wready_r <= 1'b0;
            w_held_r <= 1'b1;
            w_data_r <= wdata[3:0];
            w_lane_r <= wstrb[0];
        end
        else
        begin
            wready_r <= !w_held_r || wr_fire;
            w_held_r <= w_held_r && !wr_fire;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= tick_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == tick_pkg::SEL_NONE) ? tick_pkg::RESP_SLVERR
                : tick_pkg::RESP_OKAY;
        end
        else if (bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    // ******************************************************
    // read channel
    // ******************************************************
    always_comb
    begin
        rd_value = 32'h0;
        case (rd_sel)
            tick_pkg::SEL_CONTROL: rd_value[tick_pkg::RUN_BIT] = run_r; // R6 R9
            tick_pkg::SEL_LOW: rd_value[3:0] = count_r[3:0]; // R1
            tick_pkg::SEL_HIGH: rd_value[3:0] = hold_active_r ? held_high_r
                : count_r[7:4]; // R1 R3
            tick_pkg::SEL_ENABLE: rd_value[3:0] = enable_r; // R15
            tick_pkg::SEL_FLAGS: rd_value[3:0] = flags_r; // R13
            default: rd_value = 32'h0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= tick_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_value;
            rresp_r <= (rd_sel == tick_pkg::SEL_NONE) ? tick_pkg::RESP_SLVERR
                : tick_pkg::RESP_OKAY;
        end
        else if (rvalid_r && rready)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
        else
        begin
            arready_r <= !rvalid_r;
        end
    end

    // ******************************************************
    // run control and count
    // ******************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            run_r <= tick_pkg::RUN_RESET; // R12
        else if (wr_fire && w_lane_r && wr_sel == tick_pkg::SEL_CONTROL)
            run_r <= w_data_r[tick_pkg::RUN_BIT]; // R9
    end

    // prescaler restarts on clear so a fresh count gets a full first period
    cycle_divider #(
        .W(tick_pkg::DIV_W)
    ) u_tick_div (
        .clk(clk),
        .rst_n(rst_n),
        .restart(clear_wr),
        .run(run_r),
        .period(tick_pkg::DIV_W'(TICK_CYCLES)),
        .done(tick)
    );

    // writes to the count nibbles never reach this process
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            count_r <= tick_pkg::COUNT_RESET; // R4
        else if (clear_wr)
            count_r <= tick_pkg::COUNT_RESET; // R5 R7 R8
        else if (tick && run_r)
            count_r <= count_r + 8'h01; // R10 R11
    end

    // ******************************************************
    // high nibble hold
    // ******************************************************
    cycle_divider #(
        .W(tick_pkg::DIV_W)
    ) u_hold_div (
        .clk(clk),
        .rst_n(rst_n),
        .restart(low_read),
        .run(hold_active_r),
        .period(tick_pkg::DIV_W'(HOLD_CYCLES)),
        .done(hold_done)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hold_active_r <= 1'b0;
            held_high_r <= 4'h0;
        end
        else if (low_read)
        begin
            hold_active_r <= 1'b1; // R3
            held_high_r <= count_r[7:4];
        end
        else if (high_read || hold_done)
        begin
            hold_active_r <= 1'b0; // R3
        end
    end

    // ******************************************************
    // event flags, mask and interrupt
    // ******************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            count_prev_r <= tick_pkg::COUNT_RESET;
        else
            count_prev_r <= count_r;
    end

    // a clear that drops a watched bit counts as its falling edge too
    for (genvar g = 0; g < tick_pkg::NUM_FLAGS; g++)
    begin : g_fall
        assign fall[g] = count_prev_r[tick_pkg::FALL_BIT[g]]
            && !count_r[tick_pkg::FALL_BIT[g]]; // R16
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            flags_r <= tick_pkg::FLAGS_RESET; // R13
        else
            flags_r <= (flags_r & ~flag_clr) | fall; // R13 R16 R17
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            enable_r <= tick_pkg::ENABLE_RESET; // R15
        else if (wr_fire && w_lane_r && wr_sel == tick_pkg::SEL_ENABLE)
            enable_r <= w_data_r; // R14 R15
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_r <= 1'b0;
        else
            irq_r <= |(flags_r & enable_r); // R18
    end

    // ******************************************************
    // checks
    // ******************************************************
    a_low_read_data: assert property ( // R1
        low_read |=> rvalid && rdata[3:0] == $past(count_r[3:0]) && rdata[31:4] == 28'h0)
    else $error("low nibble read data wrong");

    a_count_ignores_write: assert property ( // R2
        wr_fire && (wr_sel == tick_pkg::SEL_LOW || wr_sel == tick_pkg::SEL_HIGH)
        && !(tick && run_r) |=> $stable(count_r))
    else $error("count changed on write to count register");

    a_high_held_read: assert property ( // R3
        high_read && hold_active_r |=> rdata[3:0] == $past(held_high_r))
    else $error("high nibble read not frozen value");

    a_hold_ends: assert property ( // R3
        (hold_done || high_read) && !low_read |=> !hold_active_r)
    else $error("hold window not closed");

    a_reset_clears: assert property (disable iff (1'b0) // R4
        !rst_n |=> count_r == 8'h00 && !run_r && flags_r == 4'h0 && enable_r == 4'h0 && !irq)
    else $error("reset did not clear state");

    a_clear_zeroes: assert property ( // R5
        clear_wr |=> count_r == 8'h00 ##1 !tick)
    else $error("clear did not zero the count");

    a_clear_reads_zero: assert property ( // R6
        rd_fire && rd_sel == tick_pkg::SEL_CONTROL |=> rdata[3:1] == 3'h0
        && rdata[0] == $past(run_r))
    else $error("control read back wrong");

    a_stopped_holds: assert property ( // R8
        !run_r && !clear_wr |=> $stable(count_r))
    else $error("count moved while stopped");

    a_run_counts: assert property ( // R11
        run_r && tick && !clear_wr |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not advance on tick");

    a_flag_sets: assert property ( // R16
        fall != 4'h0 |=> (flags_r & $past(fall)) == $past(fall))
    else $error("falling edge lost its flag");

    a_irq_follows: assert property ( // R18
        ##1 irq == |($past(flags_r) & $past(enable_r)))
    else $error("interrupt output disagrees with flags and mask");

endmodule

//--- src/tick_pkg.sv
// shared constants and types of the clock timer block
package tick_pkg;

    // ******************************************************
    // register indices (byte address is four times index)
    // ******************************************************
    localparam logic [15:0] IDX_CONTROL = 16'hff78;
    localparam logic [15:0] IDX_COUNT_LOW = 16'hff79;
    localparam logic [15:0] IDX_COUNT_HIGH = 16'hff7a;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'hffe6;
    localparam logic [15:0] IDX_EVENT_FLAGS = 16'hfff6;
    localparam int MIN_ADDR_W = 18;

    // ******************************************************
    // field positions and reset values
    // ******************************************************
    localparam int RUN_BIT = 0;
    localparam int CLEAR_BIT = 1;
    localparam int NIBBLE_W = 4;
    localparam int COUNT_W = 8;
    localparam int NUM_FLAGS = 4;
    // count bit whose falling edge raises the 32, 8, 2 and 1 hz flags
    localparam int FALL_BIT [NUM_FLAGS] = '{2, 4, 6, 7};
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    localparam logic RUN_RESET = 1'b0;

    // ******************************************************
    // bus answers
    // ******************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ******************************************************
    // timing
    // ******************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int COUNT_IN_HZ = 256;
    localparam int TICK_CYCLES = CLK_HZ / COUNT_IN_HZ;
    localparam int HOLD_MIN_NS = 480_000;
    localparam int HOLD_CYCLES = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 20;

    typedef enum logic [2:0]
    {
        SEL_NONE,
        SEL_CONTROL,
        SEL_LOW,
        SEL_HIGH,
        SEL_ENABLE,
        SEL_FLAGS
    } tick_sel_e;

endpackage

//--- src/cycle_divider.sv
// cycle counter giving a one-cycle pulse every period cycles while running
`timescale 1ns/1ps
module cycle_divider #(
    parameter int W = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic run,
    input wire logic [W-1:0] period,
    output logic done
);

    logic [W-1:0] cnt_r;
    logic done_r;

    assign done = done_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end
        else if (restart)
        begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end
        else if (run && cnt_r == period - W'(1))
        begin
            cnt_r <= '0;
            done_r <= 1'b1;
        end
        else
        begin
            // stopped phase is kept so a restart resumes mid-period
            cnt_r <= run ? cnt_r + W'(1) : cnt_r;
            done_r <= 1'b0;
        end
    end

endmodule

//--- verif/clock_timer_control_bench.sv
// self-checking bench of the clock timer register block
`timescale 1ns/1ps
module clock_timer_control_bench;
    // ******************************************************
    // signals and instance
    // ******************************************************
    // short counts keep a full count wrap near a thousand cycles
    localparam int TICKS = 4;
    localparam int HOLD = 200;
    localparam logic [17:0] A_CTL = {tick_pkg::IDX_CONTROL, 2'b00};
    localparam logic [17:0] A_LOW = {tick_pkg::IDX_COUNT_LOW, 2'b00};
    localparam logic [17:0] A_HIGH = {tick_pkg::IDX_COUNT_HIGH, 2'b00};
    localparam logic [17:0] A_EN = {tick_pkg::IDX_IRQ_ENABLE, 2'b00};
    localparam logic [17:0] A_FLG = {tick_pkg::IDX_EVENT_FLAGS, 2'b00};
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int failures = 0;
    int checks_done = 0;

    clock_timer_control #(.ADDR_W(18), .TICK_CYCLES(TICKS), .HOLD_CYCLES(HOLD)) uut (
        .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq)
    );

    always #5 clk = ~clk;

    // ******************************************************
    // shared tasks
    // ******************************************************
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic hung();
        failures++;
        $display("unexpected at %0t got %h expected %h", $time, 1'b0, 1'b1);
        report_and_stop();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [17:0] a, input logic [3:0] d, output logic [1:0] resp);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {28'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hung();
    endtask

    task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        hung();
    endtask

    task automatic wok(input logic [17:0] a, input logic [3:0] d);
        logic [1:0] r;
        wr(a, d, r);
        check_resp(r, tick_pkg::RESP_OKAY);
    endtask

    // low nibble first, so the high nibble belongs to the same moment
    task automatic rd_count(output logic [7:0] c);
        logic [31:0] lo, hi;
        logic [1:0] r;
        rd(A_LOW, lo, r);
        rd(A_HIGH, hi, r);
        c = {hi[3:0], lo[3:0]};
    endtask

    // ******************************************************
    // scenarios
    // ******************************************************
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rd(A_CTL, d, r);
        check(d, 32'h0);
        check_resp(r, tick_pkg::RESP_OKAY);
        // a write with lane 0 disabled must leave the mask alone
        wstrb <= 4'h0;
        wok(A_EN, 4'hf);
        wstrb <= 4'hf;
        rd(A_EN, d, r);
        check(d, 32'h0);
        rd(A_FLG, d, r);
        check(d, 32'h0);
        wok(A_LOW, 4'hf);
        wok(A_HIGH, 4'hf);
        rd(A_LOW, d, r);
        check(d, 32'h0);
        rd(A_HIGH, d, r);
        check(d, 32'h0);
        rd(18'h00010, d, r);
        check_resp(r, tick_pkg::RESP_SLVERR);
        check(d, 32'h0);
        wr(18'h00010, 4'h1, r);
        check_resp(r, tick_pkg::RESP_SLVERR);
    endtask

    task automatic t_run_stop();
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] c1, c2;
        wok(A_CTL, 4'h1);
        rd(A_CTL, d, r);
        check(d, 32'h1);
        repeat (60) @(posedge clk);
        wok(A_CTL, 4'h0);
        rd_count(c1);
        check({31'h0, c1 > 8'h08}, 32'h1);
        repeat (50) @(posedge clk);
        wok(A_CTL, 4'h0);
        rd_count(c2);
        check({24'h0, c2}, {24'h0, c1});
        wok(A_CTL, 4'h1);
        repeat (40) @(posedge clk);
        wok(A_CTL, 4'h0);
        rd_count(c2);
        check({31'h0, c2 > c1 && c2 - c1 < 8'h20}, 32'h1);
    endtask

    task automatic t_clear_hold();
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] c;
        wok(A_CTL, 4'h2);
        rd_count(c);
        check({24'h0, c}, 32'h0);
        repeat (30) @(posedge clk);
        rd_count(c);
        check({24'h0, c}, 32'h0);
        wok(A_CTL, 4'h1);
        repeat (60) @(posedge clk);
        wok(A_CTL, 4'h3);
        rd(A_CTL, d, r);
        check(d, 32'h1);
        rd_count(c);
        check({31'h0, c < 8'h06}, 32'h1);
        rd(A_LOW, d, r);
        repeat (120) @(posedge clk);
        rd(A_HIGH, d, r);
        check(d, 32'h0);
        rd(A_HIGH, d, r);
        check({31'h0, d[3:0] != 4'h0}, 32'h1);
        rd_count(c);
        rd(A_LOW, d, r);
        repeat (250) @(posedge clk);
        rd(A_HIGH, d, r);
        check({31'h0, d[3:0] >= c[7:4] + 4'h2}, 32'h1);
    endtask

    task automatic t_flags();
        logic [31:0] d;
        logic [1:0] r;
        wok(A_CTL, 4'h2);
        wok(A_FLG, 4'hf);
        rd(A_FLG, d, r);
        check(d, 32'h0);
        wok(A_CTL, 4'h1);
        repeat (40) @(posedge clk);
        wok(A_CTL, 4'h0);
        rd(A_FLG, d, r);
        check(d, 32'h1);
        check({31'h0, irq}, 32'h0);
        wok(A_FLG, 4'h0);
        rd(A_FLG, d, r);
        check(d, 32'h1);
        wok(A_EN, 4'h1);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wok(A_FLG, 4'h1);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wok(A_CTL, 4'h1);
        repeat (1100) @(posedge clk);
        wok(A_CTL, 4'h0);
        rd(A_FLG, d, r);
        check(d, 32'hf);
        for (int i = 0; i < 4; i++)
        begin
            wok(A_EN, 4'h1 << i);
            rd(A_EN, d, r);
            check(d, 32'h1 << i);
            check({31'h0, irq}, 32'h1);
        end
        wok(A_EN, 4'h0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wok(A_EN, 4'hf);
        wok(A_FLG, 4'hf);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
    endtask

    // reset in mid-run must throw away a running count, flags and mask
    task automatic t_mid_reset();
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] c;
        wok(A_EN, 4'h5);
        wok(A_CTL, 4'h1);
        repeat (80) @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(A_CTL, d, r);
        check(d, 32'h0);
        rd(A_EN, d, r);
        check(d, 32'h0);
        rd(A_FLG, d, r);
        check(d, 32'h0);
        rd_count(c);
        check({24'h0, c}, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask

    // ******************************************************
    // main sequence
    // ******************************************************
    initial
    begin
        clk = 1'b0;
        rst_n <= 1'b0;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        arvalid <= 1'b0;
        rready <= 1'b0;
        awaddr <= 18'h0;
        araddr <= 18'h0;
        wdata <= 32'h0;
        wstrb <= 4'hf;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_run_stop();
        t_clear_hold();
        t_flags();
        t_mid_reset();
        report_and_stop();
    end
endmodule
